// ===== hw/chan_access_defines.vh
// Constants for the channel-access and timing block: widths, timing counts, select and policy codes.
// Assumes a 20 MHz sys_clk; the sequencer writes the block through plain strobe ports.
`ifndef CHAN_ACCESS_DEFINES_VH
`define CHAN_ACCESS_DEFINES_VH

// ==========================================
// Clock and slot timing
// ==========================================
`define CLK_MHZ 20
`define SLOT_US 9
`define SLOT_CYC (`SLOT_US * `CLK_MHZ)
`define SIFS_US 10
`define SIFS_CYC (`SIFS_US * `CLK_MHZ)
`define RIFS_US 2
`define RIFS_CYC (`RIFS_US * `CLK_MHZ)
`define TSF_US_CYC `CLK_MHZ

// ==========================================
// Widths and counts
// ==========================================
`define NUM_AC 4
`define BO_W 10
`define IFS_W 12
`define NAV_W 16
`define TSF_W 64
`define SLEEP_W 32
`define NUM_OFS 2

// ==========================================
// Interframe space select codes
// ==========================================
`define IFS_SEL_SIFS 2'h0
`define IFS_SEL_RIFS 2'h1
`define IFS_SEL_PROG 2'h2

// ==========================================
// Arbitration policy codes
// ==========================================
`define POL_FIXED_HI 1'b0
`define POL_ROUND_ROBIN 1'b1

`endif

// ===== hw/chan_access.v
// Channel-access and timing logic of a WLAN MAC: interframe timer, per-category back-off,
// NAV, TSF with beacon target and offset triggers, sleep timer and clock request.
// Assumes sequencer strobes are synchronous to sys_clk; PHY and slow clock inputs are not.
// Functional notes
// - INTERFRAME_TIMING_UNIT timer starts when medium goes idle
// - INTERFRAME_TIMING_UNIT expiry pulses start trigger to transmitter
// - Per-category back-off decrements per idle slot
// - Counter at zero notifies transmit engine
// - Simultaneous zeros resolved by sequencer policy
// - Sequencer loads sleep count; slow clock counts
// - Sleep expiry restores clock, leaves suspend
// - TSF loads beacon timestamp on command
// - TBTT pulse when TSF reaches target
// - Offset triggers fire at programmed TSF values
// - NAV loaded from received duration field
// - Nonzero NAV acts as virtual carrier sense
// - Frame starts only on INTERFRAME_TIMING_UNIT trigger
// - Separate queues per quality-of-service category
`timescale 1ns/1ps
`include "chan_access_defines.vh"

module chan_access (
	input wire sys_clk,
	input wire arst_n,
	input wire phy_cca_busy,
	input wire [1:0] ifs_sel,
	input wire [`IFS_W-1:0] ifs_prog_cyc,
	input wire [`NUM_AC-1:0] bo_load,
	input wire [`BO_W-1:0] bo_load_val,
	input wire [`NUM_AC-1:0] queue_pending,
	input wire arb_policy,
	input wire [1:0] sched_queue,
	input wire sched_valid,
	input wire nav_load,
	input wire [`NAV_W-1:0] nav_duration,
	input wire tsf_load,
	input wire [`TSF_W-1:0] tsf_load_val,
	input wire tsf_add,
	input wire [`TSF_W-1:0] tsf_add_val,
	input wire tbtt_load,
	input wire [`TSF_W-1:0] tbtt_val,
	input wire [`NUM_OFS-1:0] ofs_load,
	input wire [`TSF_W-1:0] ofs_val,
	input wire sleep_start,
	input wire [`SLEEP_W-1:0] sleep_count,
	input wire slow_clk,
	output wire medium_busy,
	output reg ifs_trigger,
	output reg [`NUM_AC-1:0] bo_zero,
	output reg bo_grant_valid,
	output reg [1:0] bo_grant_ac,
	output reg tx_start,
	output reg [1:0] tx_queue,
	output reg [`NAV_W-1:0] nav_value,
	output reg [`TSF_W-1:0] tsf_value,
	output reg tbtt_pulse,
	output reg [`NUM_OFS-1:0] ofs_trigger,
	output reg mac_clk_en,
	output reg suspended,
	output reg wake_pulse,
	output reg [`SLEEP_W-1:0] slept_ticks
);

// ==========================================
// Input synchronisers
// ==========================================
reg cca_s1_r; // First stage, read only by second
reg cca_s2_r; // Synchronised PHY activity
reg slow_s1_r; // First stage of slow clock sampler
reg slow_s2_r; // Synchronised slow clock
reg slow_s3_r; // Delayed for edge detection
// Two-flop synchronisers for asynchronous inputs
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		cca_s1_r <= 1'b0;
		cca_s2_r <= 1'b0;
		slow_s1_r <= 1'b0;
		slow_s2_r <= 1'b0;
		slow_s3_r <= 1'b0;
	end else begin
		cca_s1_r <= phy_cca_busy;
		cca_s2_r <= cca_s1_r;
		slow_s1_r <= slow_clk;
		slow_s2_r <= slow_s1_r;
		slow_s3_r <= slow_s2_r;
	end
end
wire slow_tick = slow_s2_r & ~slow_s3_r; // Rising edge of slow clock

// ==========================================
// NAV timer
// ==========================================
reg [4:0] us_cnt_r; // Microsecond prescaler
wire [31:0] us_last_w = `TSF_US_CYC - 1; // Last prescaler count, full width
wire us_tick = (us_cnt_r == us_last_w[4:0]);
// Prescaler for microsecond ticks
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		us_cnt_r <= 5'h00;
	end else if (us_tick) begin
		us_cnt_r <= 5'h00;
	end else begin
		us_cnt_r <= us_cnt_r + 5'h01;
	end
end
// NAV counts down in microseconds; a load only extends it
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		nav_value <= {`NAV_W{1'b0}};
	end else if (nav_load && nav_duration > nav_value) begin
		nav_value <= nav_duration;
	end else if (us_tick && nav_value != {`NAV_W{1'b0}}) begin
		nav_value <= nav_value - 16'h0001;
	end
end
// Physical or virtual carrier sense makes the medium busy
assign medium_busy = cca_s2_r | (nav_value != {`NAV_W{1'b0}});

// ==========================================
// Interframe space timer
// ==========================================
reg [`IFS_W-1:0] ifs_cnt_r; // Idle cycles since medium went idle
reg ifs_done_r; // Trigger already given in this idle period
reg [`IFS_W-1:0] ifs_target; // Selected spacing in cycles
wire [31:0] sifs_w = `SIFS_CYC; // Short spacing, full width
wire [31:0] rifs_w = `RIFS_CYC; // Reduced spacing, full width
// Spacing selection
always @* begin
	case (ifs_sel)
		`IFS_SEL_SIFS: ifs_target = sifs_w[`IFS_W-1:0];
		`IFS_SEL_RIFS: ifs_target = rifs_w[`IFS_W-1:0];
		`IFS_SEL_PROG: ifs_target = ifs_prog_cyc;
		default: ifs_target = sifs_w[`IFS_W-1:0];
	endcase
end
// Counter restarts whenever the medium becomes busy
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		ifs_cnt_r <= {`IFS_W{1'b0}};
		ifs_done_r <= 1'b0;
		ifs_trigger <= 1'b0;
	end else if (medium_busy) begin
		ifs_cnt_r <= {`IFS_W{1'b0}};
		ifs_done_r <= 1'b0;
		ifs_trigger <= 1'b0;
	end else begin
		ifs_cnt_r <= ifs_cnt_r + 12'h001;
		ifs_trigger <= 1'b0;
		if (!ifs_done_r && ifs_cnt_r + 12'h001 >= ifs_target) begin
			ifs_trigger <= 1'b1;
			ifs_done_r <= 1'b1;
		end
	end
end

// ==========================================
// Slot clock and back-off engines
// ==========================================
reg [7:0] slot_cnt_r; // Cycles within the current slot
wire [31:0] slot_last_w = `SLOT_CYC - 1; // Last cycle of a slot, full width
wire slot_tick = (slot_cnt_r == slot_last_w[7:0]);
// Slot timer runs only after the spacing elapsed on an idle medium
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		slot_cnt_r <= 8'h00;
	end else if (medium_busy || !ifs_done_r || slot_tick) begin
		slot_cnt_r <= 8'h00;
	end else begin
		slot_cnt_r <= slot_cnt_r + 8'h01;
	end
end
reg [`BO_W-1:0] bo_cnt_r [0:`NUM_AC-1]; // One counter per access category
reg [`NUM_AC-1:0] bo_armed_r; // Category has a live back-off
integer i;
// Each engine samples the medium at slot end and decrements or pauses
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		for (i = 0; i < `NUM_AC; i = i + 1) begin
			bo_cnt_r[i] <= {`BO_W{1'b0}};
		end
		bo_armed_r <= {`NUM_AC{1'b0}};
		bo_zero <= {`NUM_AC{1'b0}};
	end else begin
		for (i = 0; i < `NUM_AC; i = i + 1) begin
			bo_zero[i] <= 1'b0;
			if (bo_load[i]) begin
				bo_cnt_r[i] <= bo_load_val;
				bo_armed_r[i] <= 1'b1;
			end else if (bo_armed_r[i] && slot_tick && !medium_busy) begin
				if (bo_cnt_r[i] == {`BO_W{1'b0}}) begin
					bo_zero[i] <= 1'b1;
					bo_armed_r[i] <= 1'b0;
				end else begin
					bo_cnt_r[i] <= bo_cnt_r[i] - 10'h001;
				end
			end
		end
	end
end

// ==========================================
// Arbitration between categories
// ==========================================
reg [1:0] rr_last_r; // Last winner for round robin
reg [1:0] win; // Combinational winner
reg win_any;
reg [1:0] idx;
integer k;
// Fixed policy favours highest index; round robin starts after last winner
always @* begin
	win = 2'h0;
	win_any = 1'b0;
	idx = 2'h0;
	for (k = `NUM_AC - 1; k >= 0; k = k - 1) begin
		if (arb_policy == `POL_ROUND_ROBIN) begin
			idx = rr_last_r - k[1:0];
		end else begin
			idx = k[1:0];
		end
		if (bo_zero[idx] && !win_any) begin
			win = idx;
			win_any = 1'b1;
		end
	end
end
// Register the single winner
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		bo_grant_valid <= 1'b0;
		bo_grant_ac <= 2'h0;
		rr_last_r <= 2'h0;
	end else begin
		bo_grant_valid <= win_any;
		if (win_any) begin
			bo_grant_ac <= win;
			rr_last_r <= win;
		end
	end
end

// ==========================================
// Transmit start on the timing trigger
// ==========================================
reg sched_r; // Scheduled frame waits for trigger
reg [1:0] sched_q_r; // Queue chosen by the sequencer
// Hold the schedule until the spacing trigger, then start
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		sched_r <= 1'b0;
		sched_q_r <= 2'h0;
		tx_start <= 1'b0;
		tx_queue <= 2'h0;
	end else begin
		tx_start <= 1'b0;
		if (sched_valid && queue_pending[sched_queue]) begin
			sched_r <= 1'b1;
			sched_q_r <= sched_queue;
		end else if (sched_r && ifs_trigger) begin
			sched_r <= 1'b0;
			tx_start <= 1'b1;
			tx_queue <= sched_q_r;
		end
	end
end

// ==========================================
// TSF timer, beacon target, offset triggers
// ==========================================
reg [`TSF_W-1:0] tbtt_r; // Target beacon time
reg [`TSF_W-1:0] ofs_r [0:`NUM_OFS-1]; // Offset trigger times
integer j;
wire tsf_step = us_tick && !tsf_load && !tsf_add; // Plain one-microsecond increment
// TSF counts microseconds; load and add commands from the sequencer
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		tsf_value <= {`TSF_W{1'b0}};
	end else if (tsf_load) begin
		tsf_value <= tsf_load_val;
	end else if (tsf_add) begin
		tsf_value <= tsf_value + tsf_add_val;
	end else if (us_tick) begin
		tsf_value <= tsf_value + 64'h1;
	end
end
// Compare TSF with target and offsets, one pulse each
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		tbtt_r <= {`TSF_W{1'b1}};
		tbtt_pulse <= 1'b0;
		ofs_trigger <= {`NUM_OFS{1'b0}};
		for (j = 0; j < `NUM_OFS; j = j + 1) begin
			ofs_r[j] <= {`TSF_W{1'b1}};
		end
	end else begin
		if (tbtt_load) begin
			tbtt_r <= tbtt_val;
		end
		tbtt_pulse <= tsf_step && (tsf_value + 64'h1 == tbtt_r);
		for (j = 0; j < `NUM_OFS; j = j + 1) begin
			if (ofs_load[j]) begin
				ofs_r[j] <= ofs_val;
			end
			ofs_trigger[j] <= tsf_step && (tsf_value + 64'h1 == ofs_r[j]);
		end
	end
end

// ==========================================
// Sleep timer on slow clock ticks
// ==========================================
reg [`SLEEP_W-1:0] sleep_cnt_r; // Remaining slow ticks
// Sequencer loads the count; clock gated off until expiry
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		sleep_cnt_r <= {`SLEEP_W{1'b0}};
		suspended <= 1'b0;
		mac_clk_en <= 1'b1;
		wake_pulse <= 1'b0;
		slept_ticks <= {`SLEEP_W{1'b0}};
	end else begin
		wake_pulse <= 1'b0;
		if (sleep_start && !suspended && sleep_count != {`SLEEP_W{1'b0}}) begin
			sleep_cnt_r <= sleep_count;
			suspended <= 1'b1;
			mac_clk_en <= 1'b0;
			slept_ticks <= {`SLEEP_W{1'b0}};
		end else if (suspended && slow_tick) begin
			slept_ticks <= slept_ticks + 32'h1;
			sleep_cnt_r <= sleep_cnt_r - 32'h1;
			if (sleep_cnt_r == 32'h1) begin
				suspended <= 1'b0;
				mac_clk_en <= 1'b1;
				wake_pulse <= 1'b1;
			end
		end
	end
end
endmodule

// ===== test/chan_partner.sv
// PHY activity and slow sleep clock model facing the channel-access block.
// Assumes the bench pulses go on a sys_clk edge; slow_clk runs free.
`timescale 1ns/1ps
// ==========================================
// Partner model
// ==========================================
module chan_partner (
	input wire sys_clk,
	input wire go,
	input wire [7:0] blen,
	output logic phy_cca_busy,
	output logic slow_clk
);
	int n = 0; // Busy cycles left
	// Slow clock, unrelated in phase to sys_clk
	initial begin
		slow_clk = 0;
		forever #813 slow_clk = ~slow_clk;
	end
	// Channel activity burst of blen cycles
	initial phy_cca_busy = 0;
	always @(posedge sys_clk) begin
		n <= go ? int'(blen) : (n > 0 ? n - 1 : 0);
		phy_cca_busy <= (n > 0);
	end
endmodule

// ===== test/chan_access_checker.sv
// Port-level assertions for the channel-access block.
// Assumes one sys_clk domain and active-low asynchronous arst_n.
`timescale 1ns/1ps
`include "chan_access_defines.vh"
module chan_access_checker (
	input wire sys_clk,
	input wire arst_n,
	input wire nav_load,
	input wire [`NAV_W-1:0] nav_duration,
	input wire tsf_load,
	input wire [`TSF_W-1:0] tsf_load_val,
	input wire tsf_add,
	input wire [`TSF_W-1:0] tsf_add_val,
	input wire sleep_start,
	input wire [`SLEEP_W-1:0] sleep_count,
	input wire medium_busy,
	input wire ifs_trigger,
	input wire [`NUM_AC-1:0] bo_zero,
	input wire bo_grant_valid,
	input wire [1:0] bo_grant_ac,
	input wire tx_start,
	input wire [`NAV_W-1:0] nav_value,
	input wire [`TSF_W-1:0] tsf_value,
	input wire tbtt_pulse,
	input wire mac_clk_en,
	input wire suspended,
	input wire wake_pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================
	// Assertions
	// ==========================================
	a_nav_busy: assert property (nav_value != 0 |-> medium_busy)
		else $error("medium not busy while nav set");
	a_trig_idle: assert property (ifs_trigger |-> $past(!medium_busy))
		else $error("ifs trigger while busy");
	a_trig_pulse: assert property (ifs_trigger |=> !ifs_trigger)
		else $error("ifs trigger longer than one cycle");
	a_tx_on_trig: assert property (tx_start |-> $past(ifs_trigger))
		else $error("tx start without ifs trigger");
	a_grant_cause: assert property (bo_grant_valid |->
		(($past(bo_zero) >> bo_grant_ac) & 4'h1) == 4'h1)
		else $error("grant to category not at zero");
	a_nav_load: assert property (nav_load && nav_duration > nav_value
		|=> nav_value == $past(nav_duration))
		else $error("nav not loaded");
	a_tsf_load: assert property (tsf_load |=> tsf_value == $past(tsf_load_val))
		else $error("tsf not loaded");
	a_tsf_add: assert property (tsf_add && !tsf_load
		|=> tsf_value == $past(tsf_value) + $past(tsf_add_val))
		else $error("tsf not advanced");
	a_sleep_in: assert property (sleep_start && !suspended && sleep_count != 0
		|=> suspended && !mac_clk_en)
		else $error("sleep not entered");
	a_wake_out: assert property ($fell(suspended) |-> wake_pulse && mac_clk_en)
		else $error("wake without clock restore");
	a_bo_idle: assert property (bo_zero != 4'h0 |-> $past(!medium_busy))
		else $error("back-off expired while medium busy");
	// Main scenarios reached
	c_trig: cover property (ifs_trigger);
	c_tx: cover property (tx_start);
	c_tbtt: cover property (tbtt_pulse);
	c_wake: cover property (wake_pulse);
endmodule
bind chan_access chan_access_checker u_chk (.*);

// ===== test/tb.sv
// Self-checking bench for the channel-access block.
// Assumes a 50 ns sys_clk and the partner model for PHY activity.
`timescale 1ns/1ps
`include "chan_access_defines.vh"
module tb;
	// ==========================================
	// Signals
	// ==========================================
	logic sys_clk = 0, arst_n = 0, arb_policy = 0, sched_valid = 0, nav_load = 0;
	logic tsf_load = 0, tsf_add = 0, tbtt_load = 0, sleep_start = 0, go = 0;
	logic phy_cca_busy, slow_clk, medium_busy, ifs_trigger, bo_grant_valid, tx_start;
	logic tbtt_pulse, mac_clk_en, suspended, wake_pulse;
	logic [7:0] blen = 8'h10;
	logic [1:0] ifs_sel = 0, sched_queue = 0, bo_grant_ac, tx_queue;
	logic [`IFS_W-1:0] ifs_prog_cyc = 0;
	logic [`NUM_AC-1:0] bo_load = 0, queue_pending = 0, bo_zero;
	logic [`BO_W-1:0] bo_load_val = 0;
	logic [`NAV_W-1:0] nav_duration = 0, nav_value;
	logic [`TSF_W-1:0] tsf_load_val = 0, tsf_add_val = 0, tbtt_val = 0, ofs_val = 0, tsf_value;
	logic [`NUM_OFS-1:0] ofs_load = 0, ofs_trigger;
	logic [`SLEEP_W-1:0] sleep_count = 0, slept_ticks;
	int n_errors = 0, checks = 0, n;
	typedef struct {logic [1:0] sel; logic [11:0] prog; int cyc;} row_t;
	row_t rows[3] = '{'{2'h0, 12'h000, `SIFS_CYC}, '{2'h1, 12'h000, `RIFS_CYC},
		'{2'h2, 12'h064, 100}};
	chan_access dut (.*);
	chan_partner phy (.*);
	initial forever #25 sys_clk = ~sys_clk;
	// ==========================================
	// Tasks
	// ==========================================
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return ifs_trigger;
			1: return bo_grant_valid;
			2: return tx_start;
			3: return tbtt_pulse;
			4: return wake_pulse;
			default: return ofs_trigger[0];
		endcase
	endfunction
	// Bounded wait for one output pulse
	task automatic wait_for(input int s);
		for (int i = 0; i < 4000 && pick(s) !== 1'b1; i++)
			@(negedge sys_clk);
		chk(pick(s), 1);
	endtask
	// Channel activity burst, returns once the medium is idle again
	task automatic burst;
		@(posedge sys_clk) go <= 1;
		@(posedge sys_clk) go <= 0;
		for (int i = 0; i < 99 && medium_busy !== 1'b1; i++)
			@(negedge sys_clk);
		for (int i = 0; i < 99 && medium_busy !== 1'b0; i++)
			@(negedge sys_clk);
	endtask
	// ==========================================
	// Watchdog and main sequence
	// ==========================================
	initial begin
		#2000000;
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1;
		@(negedge sys_clk);
		chk(mac_clk_en, 1);
		chk(tsf_value, 0);
		// Spacing from idle to trigger per select code
		foreach (rows[k]) begin
			@(posedge sys_clk) ifs_sel <= rows[k].sel;
			ifs_prog_cyc <= rows[k].prog;
			burst;
			for (n = 0; n < 4000 && ifs_trigger !== 1'b1; n++)
				@(negedge sys_clk);
			chk(n, rows[k].cyc);
		end
		// Virtual carrier sense from duration field
		@(posedge sys_clk) nav_duration <= 16'h0005;
		nav_load <= 1;
		@(posedge sys_clk) nav_load <= 0;
		@(negedge sys_clk) chk(nav_value, 16'h0005);
		chk(medium_busy, 1);
		repeat (130) @(negedge sys_clk);
		chk(nav_value, 0);
		chk(medium_busy, 0);
		// Two categories at zero together, fixed then round robin
		for (int p = 0; p < 2; p++) begin
			@(posedge sys_clk) arb_policy <= p[0];
			bo_load_val <= 10'h001;
			bo_load <= 4'ha;
			queue_pending <= 4'hf;
			@(posedge sys_clk) bo_load <= 0;
			burst;
			wait_for(1);
			chk(bo_grant_ac, p ? 2'h1 : 2'h3);
		end
		// Scheduled queue waits for the spacing trigger
		@(posedge sys_clk) sched_queue <= 2'h2;
		sched_valid <= 1;
		@(posedge sys_clk) sched_valid <= 0;
		burst;
		wait_for(2);
		chk(tx_queue, 2'h2);
		// Timer load, beacon target and offset trigger
		@(posedge sys_clk) tsf_load_val <= 64'h100;
		tsf_load <= 1;
		tbtt_val <= 64'h102;
		tbtt_load <= 1;
		ofs_val <= 64'h103;
		ofs_load <= 2'h1;
		@(posedge sys_clk) tsf_load <= 0;
		tbtt_load <= 0;
		ofs_load <= 0;
		@(negedge sys_clk) chk(tsf_value, 64'h100);
		wait_for(3);
		chk(tsf_value, 64'h102);
		wait_for(5);
		chk(tsf_value, 64'h103);
		// Sleep on the slow clock, wake, then advance time
		@(posedge sys_clk) sleep_count <= 3;
		sleep_start <= 1;
		@(posedge sys_clk) sleep_start <= 0;
		@(negedge sys_clk) chk(suspended, 1);
		chk(mac_clk_en, 0);
		wait_for(4);
		chk(mac_clk_en, 1);
		chk(slept_ticks, 3);
		@(posedge sys_clk) tsf_add_val <= 64'h40;
		tsf_add <= 1;
		@(posedge sys_clk) tsf_add <= 0;
		// Reset in mid-run
		@(posedge sys_clk) arst_n <= 0;
		@(negedge sys_clk) chk(tsf_value, 0);
		chk(mac_clk_en, 1);
		@(posedge sys_clk) arst_n <= 1;
		@(negedge sys_clk) chk(nav_value, 0);
		tally_and_finish;
	end
endmodule
